// File: arc_map.svh
`ifndef ARC_MAP_SVH
`define ARC_MAP_SVH

// ----------------------------------------------------------------------
// command and reply codes
// ----------------------------------------------------------------------
`define CMD_PROTO_CHOOSE   8'h02
`define CMD_REG_READ       8'h08
`define CMD_REG_WRITE      8'h09
`define RSP_OK             8'h00
`define RSP_BAD            8'h82
`define LEN_NONE           8'h00
`define LEN_ONE            8'h01
`define LEN_PROTO          8'h02
`define LEN_WR_SHORT       8'h03
`define LEN_WR_LONG        8'h04
`define MAX_PARAMS         4

// ----------------------------------------------------------------------
// register addresses and indexes
// ----------------------------------------------------------------------
`define ADDR_CFG_INDEX     8'h68
`define ADDR_CFG_DATA      8'h69
`define ADDR_WAKE_EVENT    8'h62
`define ADDR_SYNC_WINDOW   8'h3A
`define WINDOW_CONFIRM     8'h04
`define IDX_TUNING         8'h01
`define IDX_SUPPLY         8'h07
`define SUPPLY_BIT         4
`define FLAG_MAX           8'h01
`define READ_SIZE          8'h01

// ----------------------------------------------------------------------
// protocol codes and per-protocol defaults
// ----------------------------------------------------------------------
`define PROTO_NONE         8'h00
`define PROTO_15693        8'h01
`define PROTO_14443A       8'h02
`define PROTO_14443B       8'h03
`define PROTO_18092        8'h04
`define PROTO_15693_FULL   0
`define DEF_TUNING_A       8'hDF
`define DEF_TUNING_B       8'h2F
`define DEF_TUNING_18092   8'h5F
`define DEF_TUNING_15693_P 8'h53
`define DEF_TUNING_15693_F 8'hD3
`define DEF_WINDOW         8'h52
`define RST_TUNING         8'h00
`define WINDOW_MIN         8'h50
`define WINDOW_MAX         8'h60

// ----------------------------------------------------------------------
// host wishbone map
// ----------------------------------------------------------------------
`define WB_CMD             4'h0
`define WB_PARAM           4'h4
`define WB_STATUS          4'h8

`endif

// File: arc_pkg.sv
package arc_pkg;
  typedef enum logic [2:0] {D_CODE, D_LEN, D_PARAM, D_EXEC, D_SEND} dev_state_e;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV} host_state_e;
  typedef logic [7:0] byte_t;
endpackage

// File: arc_link_if.sv
`timescale 1ns/100ps
interface arc_link_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_ready;
  logic       d2h_valid;
  logic [7:0] d2h_data;
  logic       d2h_ready;

  modport dev
  (
    input  h2d_valid,
    input  h2d_data,
    output h2d_ready,
    output d2h_valid,
    output d2h_data,
    input  d2h_ready
  );

  modport host
  (
    output h2d_valid,
    output h2d_data,
    input  h2d_ready,
    input  d2h_valid,
    input  d2h_data,
    output d2h_ready
  );
endinterface

// File: arc_dev.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
`include "arc_map.svh"

// How it works
// - code 0x09, length 3 or 4 writes
// - first parameter 0x68 targets config index
// - second parameter is increment flag 0/1
// - index 0x01 then byte sets tuning
// - tuning upper nibble modulation, lower gain
// - good write replies 0x00 then 0x00
// - host sets index 0x01 before reading
// - protocol choice loads default tuning byte
// - tuning holds until choice, write, power-off
// - modulation codes map to depth percent
// - gain codes map to decibels
// - host keeps modulation nibble per protocol
// - host keeps window within 0x50..0x60
// - protocol choice loads window 0x52
// - window write 0x3A, flag, value, 0x04
// - host should prefer window 0x56 or 0x58
// - supply saver resets zero, one saves
// - host selects, reads, writes, reads back
// - read 0x08, replies 0x00, length, data
module arc_dev
(
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  arc_link_if.dev         LINK,
  output logic [7:0]      ANALOG_TUNING_BYTE,
  output logic [6:0]      MOD_DEPTH_PCT,
  output logic [5:0]      RX_GAIN_DB,
  output logic [7:0]      DEMOD_SYNC_WINDOW,
  output logic            TX_SUPPLY_SAVER,
  output logic [7:0]      PROTOCOL
);

  arc_pkg::dev_state_e state_reg;
  arc_pkg::byte_t      code_reg;
  arc_pkg::byte_t      len_reg;
  arc_pkg::byte_t      cnt_reg;
  arc_pkg::byte_t      par_reg [`MAX_PARAMS];
  arc_pkg::byte_t      rsp_reg [3];
  logic [1:0]          rsp_len_reg;
  logic [1:0]          snd_reg;
  logic                rdy_reg;
  logic                dv_reg;
  arc_pkg::byte_t      dd_reg;
  arc_pkg::byte_t      index_reg;
  arc_pkg::byte_t      tuning_reg;
  arc_pkg::byte_t      window_reg;
  logic                saver_reg;
  arc_pkg::byte_t      proto_reg;
  logic                take;
  logic                give;
  logic                is_wr;
  logic                flag_ok;
  logic                idx_set;
  logic                idx_wr;
  logic                win_wr;
  logic                rd_ok;
  logic                ps_ok;
  arc_pkg::byte_t      rd_data;
  arc_pkg::byte_t      ps_tuning;
  assign take = LINK.h2d_valid & rdy_reg;
  assign give = dv_reg & LINK.d2h_ready;

  // ----------------------------------------------------------------------
  // frame intake
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_reg <= arc_pkg::D_CODE;
      rdy_reg   <= 1'b1;
      code_reg  <= 8'h00;
      len_reg   <= 8'h00;
      cnt_reg   <= 8'h00;
    end
    else
    begin
      case (state_reg)
        arc_pkg::D_CODE:
        begin
          if (take)
          begin
            code_reg  <= LINK.h2d_data;
            state_reg <= arc_pkg::D_LEN;
          end
        end
        arc_pkg::D_LEN:
        begin
          if (take)
          begin
            len_reg   <= LINK.h2d_data;
            cnt_reg   <= 8'h00;
            rdy_reg   <= (LINK.h2d_data != `LEN_NONE);
            state_reg <= (LINK.h2d_data == `LEN_NONE) ? arc_pkg::D_EXEC : arc_pkg::D_PARAM;
          end
        end
        arc_pkg::D_PARAM:
        begin
          // frames longer than the parameter store are still drained, then refused
          if (take)
          begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == len_reg - 8'h01)
            begin
              rdy_reg   <= 1'b0;
              state_reg <= arc_pkg::D_EXEC;
            end
          end
        end
        arc_pkg::D_EXEC: state_reg <= arc_pkg::D_SEND;
        arc_pkg::D_SEND:
        begin
          if (give && ({1'b0, snd_reg} == {1'b0, rsp_len_reg} - 3'd1))
          begin
            rdy_reg   <= 1'b1;
            state_reg <= arc_pkg::D_CODE;
          end
        end
        default:
        begin
          rdy_reg   <= 1'b1;
          state_reg <= arc_pkg::D_CODE;
        end
      endcase
    end
  end
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < `MAX_PARAMS; i++)
        par_reg[i] <= 8'h00;
    end
    else if (take && state_reg == arc_pkg::D_PARAM && cnt_reg < 8'(`MAX_PARAMS))
      par_reg[cnt_reg[1:0]] <= LINK.h2d_data;
  end

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  assign is_wr   = (code_reg == `CMD_REG_WRITE);
  assign flag_ok = (par_reg[1] <= `FLAG_MAX);
  assign idx_set = is_wr && len_reg == `LEN_WR_SHORT && par_reg[0] == `ADDR_CFG_INDEX && flag_ok;
  assign idx_wr  = is_wr && len_reg == `LEN_WR_LONG && par_reg[0] == `ADDR_CFG_INDEX && flag_ok;
  assign win_wr  = is_wr && len_reg == `LEN_WR_LONG && par_reg[0] == `ADDR_SYNC_WINDOW
                   && flag_ok && par_reg[3] == `WINDOW_CONFIRM;
  assign rd_ok   = code_reg == `CMD_REG_READ && len_reg == `LEN_WR_SHORT && par_reg[1] == `READ_SIZE
                   && (par_reg[0] == `ADDR_CFG_DATA || par_reg[0] == `ADDR_WAKE_EVENT);

  assign rd_data = (par_reg[0] != `ADDR_CFG_DATA) ? 8'h00 : (index_reg == `IDX_TUNING) ? tuning_reg
                 : (index_reg == `IDX_SUPPLY) ? 8'({saver_reg, 4'h0}) : 8'h00;

  always_comb
  begin
    ps_ok     = (code_reg == `CMD_PROTO_CHOOSE) && (len_reg == `LEN_PROTO);
    ps_tuning = `DEF_TUNING_A;
    case (par_reg[0])
      `PROTO_14443A: ps_tuning = `DEF_TUNING_A;
      `PROTO_14443B: ps_tuning = `DEF_TUNING_B;
      `PROTO_18092:  ps_tuning = `DEF_TUNING_18092;
      `PROTO_15693:  ps_tuning = par_reg[1][`PROTO_15693_FULL] ? `DEF_TUNING_15693_F : `DEF_TUNING_15693_P;
      default:       ps_ok     = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // register effects; reset, which stands for power-off, clears all but the window, which loads 0x52
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      index_reg  <= 8'h00;
      tuning_reg <= `RST_TUNING;
      window_reg <= `DEF_WINDOW;
      saver_reg  <= 1'b0;
      proto_reg  <= `PROTO_NONE;
    end
    else if (state_reg == arc_pkg::D_EXEC)
    begin
      if (idx_set)
        index_reg <= par_reg[2];
      if (idx_wr)
      begin
        if (par_reg[2] == `IDX_TUNING)
          tuning_reg <= par_reg[3];
        if (par_reg[2] == `IDX_SUPPLY)
          saver_reg <= par_reg[3][`SUPPLY_BIT];
        index_reg <= par_reg[1][0] ? par_reg[2] + 8'h01 : par_reg[2];
      end
      if (win_wr)
      begin
        window_reg <= par_reg[2];
        if (par_reg[1][0])
          index_reg <= index_reg + 8'h01;
      end
      if (ps_ok)
      begin
        tuning_reg <= ps_tuning;
        window_reg <= `DEF_WINDOW;
        saver_reg  <= 1'b0;
        proto_reg  <= par_reg[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // reply
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rsp_reg[0]  <= 8'h00;
      rsp_reg[1]  <= 8'h00;
      rsp_reg[2]  <= 8'h00;
      rsp_len_reg <= 2'd2;
      snd_reg     <= 2'd0;
      dv_reg      <= 1'b0;
      dd_reg      <= 8'h00;
    end
    else if (state_reg == arc_pkg::D_EXEC)
    begin
      snd_reg     <= 2'd0;
      dv_reg      <= 1'b1;
      rsp_reg[0]  <= (rd_ok || idx_set || idx_wr || win_wr || ps_ok) ? `RSP_OK : `RSP_BAD;
      rsp_reg[1]  <= rd_ok ? `LEN_ONE : `LEN_NONE;
      rsp_reg[2]  <= rd_data;
      rsp_len_reg <= rd_ok ? 2'd3 : 2'd2;
      dd_reg      <= (rd_ok || idx_set || idx_wr || win_wr || ps_ok) ? `RSP_OK : `RSP_BAD;
    end
    else if (state_reg == arc_pkg::D_SEND && give)
    begin
      if ({1'b0, snd_reg} == {1'b0, rsp_len_reg} - 3'd1)
        dv_reg <= 1'b0;
      else
        dd_reg <= rsp_reg[snd_reg + 2'd1];
      snd_reg <= snd_reg + 2'd1;
    end
  end

  // ----------------------------------------------------------------------
  // analog outputs; decode lags the tuning byte by one cycle
  // ----------------------------------------------------------------------
  // codes with no listed setting decode to zero, so a bad nibble shows as zero one cycle later
  localparam logic [6:0] depth_lut [16] = '{7'd0, 7'd10, 7'd17, 7'd25, 7'd30, 7'd33, 7'd36, 7'd0,
                                            7'd0, 7'd0, 7'd0, 7'd0, 7'd0, 7'd95, 7'd0, 7'd0};
  localparam logic [5:0] gain_lut [16]  = '{6'd34, 6'd32, 6'd0, 6'd27, 6'd0, 6'd0, 6'd0, 6'd20,
                                            6'd0, 6'd0, 6'd0, 6'd0, 6'd0, 6'd0, 6'd0, 6'd8};
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      MOD_DEPTH_PCT <= 7'd0;
      RX_GAIN_DB    <= 6'd0;
    end
    else
    begin
      MOD_DEPTH_PCT <= depth_lut[tuning_reg[7:4]];
      RX_GAIN_DB    <= gain_lut[tuning_reg[3:0]];
    end
  end
  assign LINK.h2d_ready     = rdy_reg;
  assign LINK.d2h_valid     = dv_reg;
  assign LINK.d2h_data      = dd_reg;
  assign ANALOG_TUNING_BYTE = tuning_reg;
  assign DEMOD_SYNC_WINDOW  = window_reg;
  assign TX_SUPPLY_SAVER    = saver_reg;
  assign PROTOCOL           = proto_reg;
endmodule // arc_dev

// File: arc_host.sv
`timescale 1ns/100ps
`include "arc_map.svh"

module arc_host
(
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  arc_link_if.host         LINK
);

  arc_pkg::host_state_e state_reg;
  logic [31:0]          param_reg;
  arc_pkg::byte_t       code_reg;
  arc_pkg::byte_t       len_reg;
  arc_pkg::byte_t       idx_reg;
  logic                 hv_reg;
  arc_pkg::byte_t       hd_reg;
  logic                 dr_reg;
  arc_pkg::byte_t       rcnt_reg;
  arc_pkg::byte_t       rsp_code_reg;
  arc_pkg::byte_t       rsp_len_reg;
  arc_pkg::byte_t       rd_data_reg;
  logic                 done_reg;
  logic                 refused_reg;
  arc_pkg::byte_t       proto_reg;
  logic                 full_reg;
  logic                 idx_ok_reg;
  logic                 ack_reg;
  logic [31:0]          dat_reg;
  logic                 wb_req;
  logic                 start;
  logic                 refuse;
  logic                 nib_ok;
  arc_pkg::byte_t       n_code;
  arc_pkg::byte_t       n_len;
  arc_pkg::byte_t       p [4];
  arc_pkg::byte_t       next_byte;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign n_code = WB_DAT_I[7:0];
  assign n_len  = WB_DAT_I[15:8];
  assign start  = wb_req && WB_WE_I && WB_ADR_I == `WB_CMD && state_reg == arc_pkg::H_IDLE;

  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_par
      assign p[g] = param_reg[8*g +: 8];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // checks kept before a frame leaves
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (proto_reg)
      `PROTO_14443A: nib_ok = (p[3][7:4] == 4'hD);
      `PROTO_14443B,
      `PROTO_18092:  nib_ok = (p[3][7:4] >= 4'h1) && (p[3][7:4] <= 4'h4);
      `PROTO_15693:  nib_ok = full_reg ? (p[3][7:4] == 4'hD) : (p[3][7:4] >= 4'h4) && (p[3][7:4] <= 4'h6);
      default:       nib_ok = 1'b0;
    endcase
    refuse = 1'b0;
    if (n_code == `CMD_REG_WRITE && p[0] == `ADDR_SYNC_WINDOW && (p[2] < `WINDOW_MIN || p[2] > `WINDOW_MAX))
      refuse = 1'b1;
    if (n_code == `CMD_REG_WRITE && n_len == `LEN_WR_LONG && p[0] == `ADDR_CFG_INDEX
        && p[2] == `IDX_TUNING && !nib_ok)
      refuse = 1'b1;
    if (n_code == `CMD_REG_READ && p[0] == `ADDR_CFG_DATA && !idx_ok_reg)
      refuse = 1'b1;
    if (n_len > 8'(`MAX_PARAMS))
      refuse = 1'b1;
  end

  always_comb
  begin
    next_byte = p[idx_reg[1:0] - 2'd1];
    if (idx_reg == 8'h00)
      next_byte = len_reg;
  end

  // ----------------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_reg    <= arc_pkg::H_IDLE;
      code_reg     <= 8'h00;
      len_reg      <= 8'h00;
      idx_reg      <= 8'h00;
      hv_reg       <= 1'b0;
      hd_reg       <= 8'h00;
      dr_reg       <= 1'b0;
      rcnt_reg     <= 8'h00;
      rsp_code_reg <= 8'h00;
      rsp_len_reg  <= 8'h00;
      rd_data_reg  <= 8'h00;
      done_reg     <= 1'b0;
      refused_reg  <= 1'b0;
      proto_reg    <= `PROTO_NONE;
      full_reg     <= 1'b0;
      idx_ok_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        arc_pkg::H_IDLE:
        begin
          if (start)
          begin
            refused_reg <= refuse;
            done_reg    <= refuse;
            if (!refuse)
            begin
              code_reg  <= n_code;
              len_reg   <= n_len;
              idx_reg   <= 8'h00;
              hv_reg    <= 1'b1;
              hd_reg    <= n_code;
              state_reg <= arc_pkg::H_SEND;
              if (n_code == `CMD_PROTO_CHOOSE)
              begin
                proto_reg <= p[0];
                full_reg  <= p[1][`PROTO_15693_FULL];
              end
              if (n_code == `CMD_REG_WRITE && p[0] == `ADDR_CFG_INDEX)
                idx_ok_reg <= (n_len == `LEN_WR_SHORT) ? (p[2] == `IDX_TUNING) : (p[1] == 8'h00 && idx_ok_reg);
            end
          end
        end
        arc_pkg::H_SEND:
        begin
          if (LINK.h2d_ready)
          begin
            idx_reg <= idx_reg + 8'h01;
            hd_reg  <= next_byte;
            if (idx_reg == len_reg + 8'h01)
            begin
              hv_reg    <= 1'b0;
              dr_reg    <= 1'b1;
              rcnt_reg  <= 8'h00;
              state_reg <= arc_pkg::H_RECV;
            end
          end
        end
        arc_pkg::H_RECV:
        begin
          if (LINK.d2h_valid)
          begin
            rcnt_reg <= rcnt_reg + 8'h01;
            if (rcnt_reg == 8'h00)
              rsp_code_reg <= LINK.d2h_data;
            if (rcnt_reg == 8'h01)
              rsp_len_reg <= LINK.d2h_data;
            if (rcnt_reg == 8'h02)
              rd_data_reg <= LINK.d2h_data;
            if ((rcnt_reg == 8'h01 && LINK.d2h_data == 8'h00) || (rcnt_reg > 8'h01 && rcnt_reg == rsp_len_reg + 8'h01))
            begin
              dr_reg    <= 1'b0;
              done_reg  <= 1'b1;
              state_reg <= arc_pkg::H_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= arc_pkg::H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // wishbone slave: answers one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      param_reg <= 32'h0000_0000;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= wb_req;
      if (wb_req && WB_WE_I && WB_ADR_I == `WB_PARAM)
      begin
        for (int b = 0; b < 4; b++)
          if (WB_SEL_I[b])
            param_reg[8*b +: 8] <= WB_DAT_I[8*b +: 8];
      end
      if (wb_req && !WB_WE_I)
      begin
        case (WB_ADR_I)
          `WB_CMD:    dat_reg <= {16'h0000, len_reg, code_reg};
          `WB_PARAM:  dat_reg <= param_reg;
          `WB_STATUS: dat_reg <= {rd_data_reg, rsp_len_reg, rsp_code_reg, 5'h00, refused_reg, done_reg,
                                  state_reg != arc_pkg::H_IDLE};
          default:    dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK_O       = ack_reg;
  assign WB_DAT_O       = dat_reg;
  assign LINK.h2d_valid = hv_reg;
  assign LINK.h2d_data  = hd_reg;
  assign LINK.d2h_ready = dr_reg;

endmodule // arc_host

// File: arc_link_asserts.sv
`timescale 1ns/100ps
module arc_link_asserts
(
  input wire logic       CLK_SYS,
  input wire logic       SYS_RST,
  input wire logic       h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_ready,
  input wire logic       d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_ready
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // ----
  // frames sent back to back, one byte per cycle
  // ----
  sequence tk(logic [7:0] b);
    h2d_valid && h2d_ready && h2d_data == b;
  endsequence
  sequence any_b;
    h2d_valid && h2d_ready;
  endsequence
  sequence wr_tune;
    tk(8'h09) ##1 tk(8'h04) ##1 tk(8'h68) ##1 any_b ##1 tk(8'h01) ##1 any_b;
  endsequence
  sequence wr_win;
    tk(8'h09) ##1 tk(8'h04) ##1 tk(8'h3A) ##1 any_b ##1 any_b ##1 tk(8'h04);
  endsequence
  sequence rd_cfg;
    tk(8'h08) ##1 tk(8'h03) ##1 tk(8'h69) ##1 tk(8'h01) ##1 tk(8'h00);
  endsequence
  sequence ok_rply;
    d2h_valid && d2h_data == 8'h00;
  endsequence
  AST_WR_OK: assert property (wr_tune |-> ##2 ok_rply)
    else $error("tuning write not answered ok");
  AST_WIN_OK: assert property (wr_win |-> ##2 ok_rply)
    else $error("window write not answered ok");
  AST_RD_OK: assert property (rd_cfg |-> ##2 ok_rply)
    else $error("read not answered ok");
  AST_RPL_HOLD: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("reply byte dropped before taken");
  AST_RPL_BUSY: assert property (d2h_valid |-> !h2d_ready)
    else $error("device ready while replying");
  AST_RPL_LAT: assert property ($rose(d2h_valid) |-> $past(h2d_valid, 2) && $past(h2d_ready, 2) && !$past(h2d_ready))
    else $error("reply not two cycles after last byte");
  AST_RPL_LEN: assert property ($rose(d2h_valid) && d2h_ready |=> d2h_valid)
    else $error("reply without length byte");
  AST_RDY_BACK: assert property ($fell(d2h_valid) |-> h2d_ready)
    else $error("device not ready after reply");
  AST_H_HOLD: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("host byte changed before taken");
endmodule // arc_link_asserts

// File: tb_analog_config_register_write.sv
`timescale 1ns/100ps
module tb_analog_config_register_write;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  tune;
  logic [6:0]  depth;
  logic [5:0]  gain;
  logic [7:0]  win;
  logic        saver;
  logic [7:0]  proto;
  logic [31:0] st;
  logic [47:0] e;
  int          failures;
  int          compares;
  // proto, param, default, written byte, depth, gain
  logic [47:0] tab [8] = '{48'h03002F100A22, 48'h03002F211120, 48'h03002F33191B, 48'h04005F471E14,
                           48'h0100535F2108, 48'h010053602422, 48'h0200DFD15F20, 48'h0101D3D75F14};
  arc_link_if arc_link_if_inst ();
  arc_dev arc_dev_inst (.CLK_SYS(clk), .SYS_RST(rst), .LINK(arc_link_if_inst), .ANALOG_TUNING_BYTE(tune),
    .MOD_DEPTH_PCT(depth), .RX_GAIN_DB(gain), .DEMOD_SYNC_WINDOW(win), .TX_SUPPLY_SAVER(saver), .PROTOCOL(proto));
  arc_host arc_host_inst (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .LINK(arc_link_if_inst));
  arc_link_asserts arc_link_asserts_inst (.CLK_SYS(clk), .SYS_RST(rst),
    .h2d_valid(arc_link_if_inst.h2d_valid), .h2d_data(arc_link_if_inst.h2d_data),
    .h2d_ready(arc_link_if_inst.h2d_ready), .d2h_valid(arc_link_if_inst.d2h_valid),
    .d2h_data(arc_link_if_inst.d2h_data), .d2h_ready(arc_link_if_inst.d2h_ready));
  // ----
  // tasks
  // ----
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    st = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // polls status so the bench never assumes a frame length
  task automatic cmd(logic [7:0] c, logic [7:0] l, logic [31:0] p);
    wb(1'b1, 4'h4, p);
    wb(1'b1, 4'h0, {16'h0000, l, c});
    st = 32'h00000000;
    while (st[1] !== 1'b1)
      wb(1'b0, 4'h8, 32'h00000000);
  endtask
  task automatic finish_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #300000;
    failures++;
    finish_test();
  end
  // ----
  // tests
  // ----
  initial
  begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h00000000;
    failures = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("win", win, 8'h52);
    chk("saver", saver, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      e = tab[i];
      cmd(8'h02, 8'h02, {16'h0000, e[39:32], e[47:40]});
      chk("proto", proto, e[47:40]);
      chk("deflt", tune, e[31:24]);
      cmd(8'h09, 8'h04, {e[23:16], 24'h010068});
      chk("wres", st[23:8], 16'h0000);
      chk("tune", tune, e[23:16]);
      chk("depth", depth, e[15:8]);
      chk("gain", gain, e[7:0]);
      cmd(8'h09, 8'h03, 32'h00010068);
      chk("iset", st[23:8], 16'h0000);
      cmd(8'h08, 8'h03, 32'h00000169);
      chk("rd", st[31:8], {e[23:16], 16'h0100});
    end
    cmd(8'h02, 8'h02, 32'h00000004);
    cmd(8'h09, 8'h04, 32'h23010168);
    chk("tune", tune, 8'h23);
    cmd(8'h08, 8'h03, 32'h00000169);
    chk("adv", st[2], 1'b1);
    cmd(8'h09, 8'h03, 32'h00010068);
    chk("idx", st[23:8], 16'h0000);
    cmd(8'h08, 8'h03, 32'h00000169);
    chk("rdbk", st[31:24], 8'h23);
    cmd(8'h09, 8'h04, 32'h0458003A);
    chk("win", win, 8'h58);
    cmd(8'h09, 8'h04, 32'h0461003A);
    chk("wref", {st[2], win}, 9'h158);
    cmd(8'h09, 8'h04, 32'h10070068);
    chk("saver", saver, 1'b1);
    cmd(8'h02, 8'h02, 32'h00000002);
    chk("saver", saver, 1'b0);
    chk("win", win, 8'h52);
    // a reset in mid-run stands for power-off; tuning must clear and the window go back to 0x52
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("pwr", tune, 8'h00);
    chk("pwrw", win, 8'h52);
    finish_test();
  end
endmodule // tb_analog_config_register_write
